// ===== logic/adcc_pkg.sv
/*
 * Package for the converter control block: register layout, field positions,
 * channel codes and controller states.
 * Assumes a byte-wide register port on the bus clock.
 */
`default_nettype none
package adcc_pkg;
	// Register selects on the byte register port
	localparam logic [2:0] ADDR_SC_A      = 3'h0;
	localparam logic [2:0] ADDR_SC_B      = 3'h1;
	localparam logic [2:0] ADDR_RES_HIGH  = 3'h2;
	localparam logic [2:0] ADDR_RES_LOW   = 3'h3;
	localparam logic [2:0] ADDR_CMP_HIGH  = 3'h4;
	localparam logic [2:0] ADDR_CMP_LOW   = 3'h5;
	// conv_status_control_a fields
	localparam int BIT_FLAG   = 7;
	localparam int BIT_IEN    = 6;
	localparam int BIT_CONT   = 5;
	localparam int CH_MSB     = 4;
	// conv_status_control_b fields
	localparam int BIT_ACTIVE = 7;
	localparam int BIT_TRIG   = 6;
	localparam int BIT_CMPEN  = 5;
	localparam int BIT_CMPGT  = 4;
	localparam logic [7:0] SC_A_RESET = 8'h1f;
	localparam logic [7:0] SC_B_RESET = 8'h00;
	// Channel codes
	localparam logic [4:0] CH_LAST_INPUT = 5'h1b;
	localparam logic [4:0] CH_RESERVED   = 5'h1c;
	localparam logic [4:0] CH_REF_HIGH   = 5'h1d;
	localparam logic [4:0] CH_REF_LOW    = 5'h1e;
	localparam logic [4:0] CH_OFF        = 5'h1f;
	localparam int RES_W = 10;
	typedef enum logic [1:0] {ST_IDLE, ST_START, ST_BUSY} adcc_state_t;
endpackage
`default_nettype wire

// ===== logic/adcc_result_mem.sv
/*
 * Result and compare-value store: four bytes, registered read data.
 * Assumes writes and reads come from the control block on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
module adcc_result_mem (
	// Clock and reset
	input  wire logic       sys_clk,
	input  wire logic       resetn,
	// Write port
	input  wire logic       wr_en,
	input  wire logic [1:0] wr_addr,
	input  wire logic [7:0] wr_data,
	// Read port
	input  wire logic [1:0] rd_addr,
	output logic      [7:0] rd_data
);
	logic [7:0] mem_reg [4];

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < 4; i++) begin
				mem_reg[i] <= 8'h00;
			end
		end else if (wr_en) begin
			mem_reg[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			rd_data <= 8'h00;
		end else begin
			rd_data <= mem_reg[rd_addr];
		end
	end
endmodule
`default_nettype wire

// ===== logic/adcc_control.sv
/*
 * Conversion control for a successive approximation converter: control and
 * status registers, triggering, compare, completion flag and interrupt.
 * Assumes the analog core takes core_start pulses, reports core_done with its
 * result, and that the register port is synchronous to sys_clk.
 */
`timescale 1ns/1ps
`default_nettype none
// Function
// - Writing control register A aborts and restarts conversion unless channel is all ones; with hardware trigger the code only aborts.
// - Complete flag bit 7 is read-only; the bit 7 value written to control register A is ignored.
// - Compare disabled: complete flag sets at every conversion end.
// - Compare enabled: complete flag sets only when compare is true.
// - Complete flag clears on control register A write or low result read.
// - Flag setting while interrupt enable bit 6 is one raises the interrupt.
// - Continuous off: one conversion per write or per hardware trigger.
// - Continuous with software trigger: repeated conversions after a register write.
// - Continuous with hardware trigger: continuous conversions start on a trigger event.
// - Channel select is bits 4:0 of control register A.
// - All-ones channel turns converter off and isolates the input.
// - Stopping by all-ones code performs no further single conversion.
// - Without continuous mode, converter enters low power after each conversion.
// - Codes 00000 to 11011 select analog inputs zero to twenty-seven.
// - 11100 reserved, 11101 high reference, 11110 low reference.
// - Trigger select bit chooses software or hardware triggering.
// - Read-only active bit sets on start, clears on completion or abort.
// - Compare direction: zero means below, one means at or above.
module adcc_control
	import adcc_pkg::*;
(
	// Clock and reset
	input  wire logic                 sys_clk,
	input  wire logic                 resetn,
	// Register port
	input  wire logic                 reg_wr,
	input  wire logic                 reg_rd,
	input  wire logic [2:0]           reg_addr,
	input  wire logic [7:0]           reg_wdata,
	output logic      [7:0]           reg_rdata,
	// Hardware trigger
	input  wire logic                 hw_trigger_in,
	// Analog core
	output logic                      core_start,
	output logic                      core_abort,
	output logic                      core_power_on,
	output logic      [4:0]           core_channel,
	output logic                      core_sel_input,
	output logic                      core_sel_ref_high,
	output logic                      core_sel_ref_low,
	input  wire logic                 core_done,
	input  wire logic [RES_W-1:0]     core_result,
	// Interrupt request
	output logic                      conv_irq
);
	////////////////////////////////////////////////////////////////
	logic [7:0]        sc_a_reg;
	logic [7:0]        sc_b_reg;
	logic              conv_complete_flag;
	logic              conv_active;
	logic              cont_run_reg;
	adcc_state_t       state_reg;
	logic [2:0]        trig_sync_reg;
	logic              trig_prev_reg;
	logic [RES_W-1:0]  cmp_value;
	logic [7:0]        mem_rdata;
	logic [2:0]        rd_addr_reg;
	logic              rd_pending_reg;

	logic [4:0] channel_select;
	logic       continuous_enable;
	logic       conv_irq_enable;
	logic       trigger_select;
	logic       compare_enable;
	logic       compare_greater_select;
	assign channel_select         = sc_a_reg[CH_MSB:0];
	assign continuous_enable      = sc_a_reg[BIT_CONT];
	assign conv_irq_enable        = sc_a_reg[BIT_IEN];
	assign trigger_select         = sc_b_reg[BIT_TRIG];
	assign compare_enable         = sc_b_reg[BIT_CMPEN];
	assign compare_greater_select = sc_b_reg[BIT_CMPGT];

	logic wr_sc_a;
	logic wr_sc_b;
	logic rd_res_low;
	assign wr_sc_a    = reg_wr && (reg_addr == ADDR_SC_A);
	assign wr_sc_b    = reg_wr && (reg_addr == ADDR_SC_B);
	assign rd_res_low = reg_rd && (reg_addr == ADDR_RES_LOW);

	function automatic logic compare_true(input logic [RES_W-1:0] res,
			input logic [RES_W-1:0] cv, input logic gt);
		compare_true = gt ? (res >= cv) : (res < cv);
	endfunction

	////////////////////////////////////////////////////////////////
	// Trigger synchroniser; stage 0 is only read by stage 1
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			trig_sync_reg <= 3'h0;
			trig_prev_reg <= 1'b0;
		end else begin
			trig_sync_reg <= {trig_sync_reg[1:0], hw_trigger_in};
			if (trig_sync_reg[2] == trig_sync_reg[1]) begin
				trig_prev_reg <= trig_sync_reg[2];
			end
		end
	end

	logic hw_event;
	// Rising edge once stages one and two agree
	assign hw_event = trig_sync_reg[2] && trig_sync_reg[1] && !trig_prev_reg;

	////////////////////////////////////////////////////////////////
	// Control registers
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			sc_a_reg <= SC_A_RESET;
		end else if (wr_sc_a) begin
			sc_a_reg <= {1'b0, reg_wdata[BIT_IEN:0]};
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			sc_b_reg <= SC_B_RESET;
		end else if (wr_sc_b) begin
			sc_b_reg <= {1'b0, reg_wdata[BIT_TRIG:BIT_CMPGT], 4'h0};
		end
	end

	////////////////////////////////////////////////////////////////
	// Conversion sequencing
	logic conv_end;
	logic sw_request;
	logic hw_request;
	logic start_now;
	logic off_code_wr;
	assign conv_end    = (state_reg == ST_BUSY) && core_done;
	assign off_code_wr = wr_sc_a && (reg_wdata[CH_MSB:0] == CH_OFF);
	assign sw_request  = wr_sc_a && !off_code_wr && !trigger_select;
	// A control write in the trigger cycle wins, so an off code is never overtaken
	assign hw_request  = hw_event && trigger_select && !wr_sc_a
		&& (channel_select != CH_OFF);
	// Restart after an end only in continuous mode
	assign start_now   = conv_end && cont_run_reg && continuous_enable
		&& (channel_select != CH_OFF);

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			state_reg <= ST_IDLE;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					if (sw_request || hw_request) begin
						state_reg <= ST_START;
					end
				end
				ST_START: begin
					if (off_code_wr || (wr_sc_a && trigger_select)) begin
						state_reg <= ST_IDLE;
					end else if (!sw_request) begin
						state_reg <= ST_BUSY;
					end
				end
				ST_BUSY: begin
					if (off_code_wr || (wr_sc_a && trigger_select)) begin
						state_reg <= ST_IDLE;
					end else if (sw_request) begin
						state_reg <= ST_START;
					end else if (start_now) begin
						state_reg <= ST_START;
					end else if (core_done) begin
						state_reg <= ST_IDLE;
					end
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// Continuous run latched by the starting request
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			cont_run_reg <= 1'b0;
		end else if (off_code_wr || (wr_sc_a && trigger_select)) begin
			cont_run_reg <= 1'b0;
		end else if (sw_request) begin
			cont_run_reg <= reg_wdata[BIT_CONT];
		end else if (hw_request && state_reg == ST_IDLE) begin
			cont_run_reg <= continuous_enable;
		end
	end

	assign conv_active = (state_reg != ST_IDLE);
	assign core_start  = (state_reg == ST_START);
	assign core_abort  = (state_reg == ST_BUSY) && wr_sc_a;
	// Powered only while converting; idle is the low-power state
	assign core_power_on = conv_active && (channel_select != CH_OFF);

	////////////////////////////////////////////////////////////////
	// Channel routing
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			core_channel      <= 5'h00;
			core_sel_input    <= 1'b0;
			core_sel_ref_high <= 1'b0;
			core_sel_ref_low  <= 1'b0;
		end else begin
			core_channel      <= channel_select;
			core_sel_input    <= (channel_select <= CH_LAST_INPUT);
			core_sel_ref_high <= (channel_select == CH_REF_HIGH);
			core_sel_ref_low  <= (channel_select == CH_REF_LOW);
		end
	end
	// CH_RESERVED and CH_OFF leave every source switch open

	////////////////////////////////////////////////////////////////
	// Completion flag and interrupt
	logic flag_set;
	assign flag_set = conv_end && !wr_sc_a
		&& (!compare_enable || compare_true(core_result, cmp_value,
			compare_greater_select));

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			conv_complete_flag <= 1'b0;
		end else if (flag_set) begin
			conv_complete_flag <= 1'b1;
		end else if (wr_sc_a || rd_res_low) begin
			conv_complete_flag <= 1'b0;
		end
	end

	// Level follows the flag while enabled
	assign conv_irq = conv_complete_flag && conv_irq_enable;

	////////////////////////////////////////////////////////////////
	// Result and compare storage
	logic       mem_wr;
	logic [1:0] mem_waddr;
	logic [7:0] mem_wdata;
	logic       res_wr_high;
	logic       cmp_wr;
	assign cmp_wr   = reg_wr && (reg_addr == ADDR_CMP_HIGH || reg_addr == ADDR_CMP_LOW);
	// Result update shares the store; low byte is held in a register
	logic [7:0] res_low_reg;
	assign res_wr_high = flag_set;
	assign mem_wr    = cmp_wr || res_wr_high;
	assign mem_waddr = cmp_wr ? reg_addr[1:0] : ADDR_RES_HIGH[1:0];
	assign mem_wdata = cmp_wr ? reg_wdata
		: {{(8-(RES_W-8)){1'b0}}, core_result[RES_W-1:8]};

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			res_low_reg <= 8'h00;
			cmp_value   <= '0;
		end else begin
			if (flag_set) begin
				res_low_reg <= core_result[7:0];
			end
			if (reg_wr && reg_addr == ADDR_CMP_HIGH) begin
				cmp_value[RES_W-1:8] <= reg_wdata[RES_W-9:0];
			end
			if (reg_wr && reg_addr == ADDR_CMP_LOW) begin
				cmp_value[7:0] <= reg_wdata;
			end
		end
	end

	adcc_result_mem u_store (
		.sys_clk (sys_clk),
		.resetn  (resetn),
		.wr_en   (mem_wr),
		.wr_addr (mem_waddr),
		.wr_data (mem_wdata),
		.rd_addr (reg_addr[1:0]),
		.rd_data (mem_rdata)
	);

	////////////////////////////////////////////////////////////////
	// Read data, one cycle after the read strobe
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			rd_addr_reg    <= 3'h0;
			rd_pending_reg <= 1'b0;
		end else begin
			rd_addr_reg    <= reg_addr;
			rd_pending_reg <= reg_rd;
		end
	end

	always_comb begin
		reg_rdata = 8'h00;
		if (rd_pending_reg) begin
			case (rd_addr_reg)
				ADDR_SC_A:     reg_rdata = {conv_complete_flag, sc_a_reg[BIT_IEN:0]};
				ADDR_SC_B:     reg_rdata = {conv_active, sc_b_reg[BIT_TRIG:0]};
				ADDR_RES_HIGH: reg_rdata = mem_rdata;
				ADDR_RES_LOW:  reg_rdata = res_low_reg;
				ADDR_CMP_HIGH: reg_rdata = mem_rdata;
				ADDR_CMP_LOW:  reg_rdata = mem_rdata;
				default:       reg_rdata = 8'h00;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// Checks
	chk_flag_readonly: assert property (@(posedge sys_clk) disable iff (!resetn)
		wr_sc_a && !flag_set |=> !conv_complete_flag)
		else $error("complete flag survived a control write");
	chk_flag_on_end: assert property (@(posedge sys_clk) disable iff (!resetn)
		conv_end && !wr_sc_a && !compare_enable |=> conv_complete_flag)
		else $error("flag not set at conversion end");
	chk_cmp_false: assert property (@(posedge sys_clk) disable iff (!resetn)
		conv_end && compare_enable && !compare_true(core_result, cmp_value,
			compare_greater_select) && !conv_complete_flag |=> !conv_complete_flag)
		else $error("flag set on false compare");
	chk_read_clears: assert property (@(posedge sys_clk) disable iff (!resetn)
		rd_res_low && !flag_set |=> !conv_complete_flag)
		else $error("low result read left flag set");
	chk_irq_follow: assert property (@(posedge sys_clk) disable iff (!resetn)
		$rose(conv_complete_flag) && conv_irq_enable |-> conv_irq)
		else $error("interrupt missing");
	chk_write_start: assert property (@(posedge sys_clk) disable iff (!resetn)
		sw_request |=> core_start)
		else $error("write did not start conversion");
	chk_off_stops: assert property (@(posedge sys_clk) disable iff (!resetn)
		off_code_wr |=> !conv_active ##1 !core_start)
		else $error("conversion after off code");
	chk_single_idle: assert property (@(posedge sys_clk) disable iff (!resetn)
		conv_end && !cont_run_reg && !wr_sc_a |=> !conv_active)
		else $error("single conversion did not go idle");
	chk_hw_once: assert property (@(posedge sys_clk) disable iff (!resetn)
		hw_event |=> !hw_event)
		else $error("trigger edge counted twice");
endmodule
`default_nettype wire

// ===== test/adcc_core_model.sv
/*
 * Behavioural analog converter core facing the control block.
 * Assumes one conversion per core_start pulse, LAT clocks long, abortable.
 */
`timescale 1ns/1ps
`default_nettype none
module adcc_core_model
	import adcc_pkg::*;
#(
	parameter int LAT = 12
) (
	// Clock and reset
	input  wire logic             sys_clk,
	input  wire logic             resetn,
	// Control from the block
	input  wire logic             core_start,
	input  wire logic             core_abort,
	// Result to the block
	input  wire logic [RES_W-1:0] result_in,
	output logic                  core_done,
	output logic      [RES_W-1:0] core_result
);
	logic       busy_reg;
	logic [7:0] cnt_reg;

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			busy_reg  <= 1'b0;
			cnt_reg   <= 8'h00;
			core_done <= 1'b0;
		end else begin
			core_done <= 1'b0;
			if (core_start) begin
				busy_reg <= 1'b1;
				cnt_reg  <= 8'(LAT - 1);
			end else if (core_abort) begin
				busy_reg <= 1'b0;
			end else if (busy_reg && cnt_reg == 8'h00) begin
				busy_reg  <= 1'b0;
				core_done <= 1'b1;
			end else if (busy_reg) begin
				cnt_reg <= cnt_reg - 8'h01;
			end
		end
	end

	// Junk outside the done cycle, so a late capture shows up
	assign core_result = core_done ? result_in : ~result_in;
endmodule
`default_nettype wire

// ===== test/tb_adc_conversion_control.sv
/*
 * Self-checking bench for the converter control block.
 * Assumes the behavioural core model and the byte register port of the block.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_fail++; \
	$display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module tb_adc_conversion_control
	import adcc_pkg::*;
;
	logic             sys_clk, resetn, reg_wr, reg_rd, hw_trigger_in;
	logic [2:0]       reg_addr;
	logic [7:0]       reg_wdata, reg_rdata, d;
	logic             core_start, core_abort, core_power_on, core_done, conv_irq;
	logic [4:0]       core_channel;
	logic             core_sel_input, core_sel_ref_high, core_sel_ref_low;
	logic [RES_W-1:0] core_result, result_in;
	int               n_fail, compares, n_start, n_abort, s0, i;
	logic [4:0]       chs [5] = '{5'h00, 5'h1b, 5'h1c, 5'h1d, 5'h1e};
	logic [7:0]       cb [5] = '{8'h20, 8'h20, 8'h30, 8'h30, 8'h30};
	logic [9:0]       cr [5] = '{10'h050, 10'h200, 10'h200, 10'h100, 10'h0ff};
	logic             cf [5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};

	adcc_control u_dut (.sys_clk(sys_clk), .resetn(resetn), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .hw_trigger_in(hw_trigger_in), .core_start(core_start),
		.core_abort(core_abort), .core_power_on(core_power_on),
		.core_channel(core_channel), .core_sel_input(core_sel_input),
		.core_sel_ref_high(core_sel_ref_high), .core_sel_ref_low(core_sel_ref_low),
		.core_done(core_done), .core_result(core_result), .conv_irq(conv_irq));
	adcc_core_model #(.LAT(12)) u_core (.sys_clk(sys_clk), .resetn(resetn),
		.core_start(core_start), .core_abort(core_abort), .result_in(result_in),
		.core_done(core_done), .core_result(core_result));

	always #10 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		if (core_start === 1'b1) n_start++;
		if (core_abort === 1'b1) n_abort++;
	end
	////////////////////////////////////////////////////////////////////////////
	task automatic wr(input logic [2:0] a, input logic [7:0] v);
		@(posedge sys_clk); #1;
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = v;
		@(posedge sys_clk); #1;
		reg_wr = 1'b0;
	endtask
	task automatic rd(input logic [2:0] a, output logic [7:0] v);
		@(posedge sys_clk); #1;
		reg_rd = 1'b1;
		reg_addr = a;
		@(posedge sys_clk); #1;
		reg_rd = 1'b0;
		v = reg_rdata;
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	// Flag and irq land one clock after the done pulse
	task automatic wait_done;
		int k;
		for (k = 0; k < 100 && core_done !== 1'b1; k++) idle(1);
		`CHK("done seen", 1'b1, core_done)
		idle(1);
	endtask
	task automatic single(input logic [7:0] v, input logic [9:0] res, input logic f);
		logic [7:0] q;
		s0 = n_start;
		result_in = res;
		wr(ADDR_SC_A, v);
		rd(ADDR_SC_B, q);
		`CHK("active set", 1'b1, q[BIT_ACTIVE])
		`CHK("power on", 1'b1, core_power_on)
		wait_done;
		`CHK("irq", f & v[BIT_IEN], conv_irq)
		rd(ADDR_SC_A, q);
		`CHK("sc_a done", {f, v[6:0]}, q)
		rd(ADDR_SC_B, q);
		`CHK("active clear", 1'b0, q[BIT_ACTIVE])
		`CHK("power off", 1'b0, core_power_on)
		`CHK("one start", s0 + 1, n_start)
	endtask
	task report_and_stop;
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////
	initial begin
		#200000;
		n_fail++;
		report_and_stop;
	end
	initial begin
		{sys_clk, resetn, reg_wr, reg_rd, hw_trigger_in} = 5'h00;
		{reg_addr, reg_wdata, result_in} = 21'h0;
		{n_fail, compares, n_start, n_abort} = '0;
		idle(3);
		resetn = 1'b1;
		rd(ADDR_SC_A, d);
		`CHK("sc_a reset", SC_A_RESET, d)
		rd(ADDR_SC_B, d);
		`CHK("sc_b reset", SC_B_RESET, d)
		single(8'hc5, 10'h2a5, 1'b1);
		rd(ADDR_RES_HIGH, d);
		`CHK("res high", 8'h02, d)
		rd(ADDR_RES_LOW, d);
		`CHK("res low", 8'ha5, d)
		rd(ADDR_SC_A, d);
		`CHK("flag cleared by read", 8'h45, d)
		`CHK("irq cleared", 1'b0, conv_irq)
		single(8'h46, 10'h001, 1'b1);
		s0 = n_start;
		wr(ADDR_SC_A, 8'h1f);
		rd(ADDR_SC_A, d);
		`CHK("flag cleared by write", 8'h1f, d)
		`CHK("off no start", s0, n_start)
		`CHK("sel off", 3'b000, {core_sel_input, core_sel_ref_high, core_sel_ref_low})
		for (i = 0; i < 5; i++) begin
			single({3'h0, chs[i]}, 10'h001, 1'b1);
			`CHK("channel", chs[i], core_channel)
			`CHK("sel", {chs[i] <= CH_LAST_INPUT, chs[i] == CH_REF_HIGH,
				chs[i] == CH_REF_LOW}, {core_sel_input, core_sel_ref_high,
				core_sel_ref_low})
		end
		s0 = n_abort;
		wr(ADDR_SC_A, 8'h07);
		idle(3);
		wr(ADDR_SC_A, 8'h07);
		`CHK("abort on write", s0 + 1, n_abort)
		wait_done;
		wr(ADDR_CMP_HIGH, 8'h01);
		wr(ADDR_CMP_LOW, 8'h00);
		wr(ADDR_SC_B, 8'hff);
		rd(ADDR_SC_B, d);
		`CHK("sc_b fields", 8'h70, d)
		rd(ADDR_CMP_HIGH, d);
		`CHK("cmp high", 8'h01, d)
		rd(ADDR_CMP_LOW, d);
		`CHK("cmp low", 8'h00, d)
		for (i = 0; i < 5; i++) begin
			wr(ADDR_SC_B, cb[i]);
			single(8'h44, cr[i], cf[i]);
		end
		wr(ADDR_SC_B, 8'h00);
		s0 = n_start;
		wr(ADDR_SC_A, 8'h23);
		idle(80);
		`CHK("sw continuous", 1'b1, n_start - s0 >= 4)
		wr(ADDR_SC_A, 8'h3f);
		s0 = n_start;
		idle(40);
		`CHK("stop no start", s0, n_start)
		`CHK("stop power off", 1'b0, core_power_on)
		wr(ADDR_SC_B, 8'h40);
		wr(ADDR_SC_A, 8'h02);
		s0 = n_start;
		idle(20);
		`CHK("hw no sw start", s0, n_start)
		hw_trigger_in = 1'b1;
		idle(30);
		hw_trigger_in = 1'b0;
		idle(20);
		`CHK("hw one start", s0 + 1, n_start)
		wr(ADDR_SC_A, 8'h22);
		s0 = n_start;
		hw_trigger_in = 1'b1;
		idle(3);
		hw_trigger_in = 1'b0;
		idle(80);
		`CHK("hw continuous", 1'b1, n_start - s0 >= 4)
		wr(ADDR_SC_A, 8'h3f);
		report_and_stop;
	end
endmodule
`default_nettype wire
